// ==== ivc_pkg.sv ====
/*
  Constants, register map and state codes of the vectored interrupt
  controller. Assumes one 100 MHz clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - All peripheral requests merge into one request towards the CPU core.
// - Up to eight exception and trap vectors precede the user sources.
// - Each user source carries a software priority of one to seven.
// - Equal priority ties resolve by fixed order, never by a setting.
// - Entry and return take a fixed count of cycles for every source.
// - The primary vector table starts at program address 000004h.
// - The table has 126 entries: eight traps, then 118 sources.
// - Each entry is a 24-bit handler start address.
// - Lower vector position outranks higher; vector 0 outranks all.
// - This controller implements 28 sources and four traps.
// - Alternate table follows the primary; its select bit redirects every vector.
// - Alternate table keeps the same entry order as the primary.
// - Reset bypasses the controller and forces the program counter to zero.
// - Level is three status bits plus bit three; bit three or seven blocks.
// - The three level bits turn read-only while nesting is disabled.

`default_nettype none

package ivc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int VEC_W = 24;
  localparam int PRIO_W = 3;
  localparam int NUM_SRC = 28;
  localparam int NUM_TRAP = 4;
  localparam int MAX_TRAP = 8;
  localparam int SLOT_W = 5;
  localparam int TBL_ENTRIES = 126;
  localparam int VEC_STEP = 2;

  // ---------------------------------------------------------------
  // Program addresses
  // ---------------------------------------------------------------
  localparam logic [23:0] RESET_PC = 24'h00_0000;
  localparam logic [23:0] TBL_BASE = 24'h00_0004;
  localparam logic [23:0] ALT_TBL_BASE = TBL_BASE + 24'(TBL_ENTRIES * VEC_STEP);

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h01;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_CORE = 8'h03;
  localparam logic [7:0] OFF_EN_LO = 8'h04;
  localparam logic [7:0] OFF_EN_HI = 8'h05;
  localparam logic [7:0] OFF_EV_STAT = 8'h06;
  localparam logic [7:0] OFF_EV_MASK = 8'h07;
  localparam logic [7:0] OFF_VEC_IDX = 8'h08;
  localparam logic [7:0] OFF_VEC_LO = 8'h09;
  localparam logic [7:0] OFF_VEC_HI = 8'h0A;
  localparam logic [7:0] OFF_ACTIVE = 8'h0B;
  localparam logic [7:0] OFF_PRIO0 = 8'h10;

  // ---------------------------------------------------------------
  // Field positions, reset values, timing
  // ---------------------------------------------------------------
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_SEL_BIT = 15;
  localparam int LEVEL_LSB = 5;
  localparam int LEVEL3_BIT = 3;
  localparam int EV_ENTRY = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_RETURN = 2;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam int RET_LAT = 2;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_FETCH = 6'b00_0010,
    ST_LOAD = 6'b00_0100,
    ST_REQ = 6'b00_1000,
    ST_SERVE = 6'b01_0000,
    ST_RET = 6'b10_0000
  } ivc_state_e;

endpackage : ivc_pkg

`default_nettype wire

// ==== ivc_vec_mem.sv ====
/*
  Vector table store: one write port, one registered read port.
  Assumes write and read addresses come from logic on the same clock.
*/
`default_nettype none

module ivc_vec_mem #(
  parameter int WIDTH = 24,
  parameter int AW = 6
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [2**AW];

  // Write port
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : ivc_vec_mem

`default_nettype wire

// ==== ivc_ctrl.sv ====
/*
  Vectored interrupt controller top: register port, winner selection,
  vector fetch sequencer and event interrupt.
  Assumes requests, traps and CPU handshakes come from same-clock logic.
*/
// Implementation choices: the register addresses and strobed register access.
`default_nettype none

module ivc_ctrl
  import ivc_pkg::*;
#(
  parameter int N_SRC = NUM_SRC,
  parameter int N_TRAP = NUM_TRAP
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [N_SRC-1:0] src_req_i,
  input wire logic [N_TRAP-1:0] trap_req_i,
  input wire logic cpu_ack_i,
  input wire logic cpu_ret_i,
  output logic cpu_req_o,
  output logic [6:0] cpu_vec_num_o,
  output logic [VEC_W-1:0] cpu_vec_loc_o,
  output logic [VEC_W-1:0] handler_pc_o,
  output logic [3:0] cpu_level_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Registers and wires
  // ---------------------------------------------------------------
  ivc_state_e state, next_state;
  logic nesting_disable, alt_table_select;
  logic [2:0] cpu_level_bits;
  logic cpu_level_bit3;
  logic [N_SRC-1:0] src_en;
  logic [PRIO_W-1:0] prio [N_SRC];
  logic [2:0] ev_stat, ev_mask;
  logic [5:0] vec_idx;
  logic [15:0] vec_lo;
  logic [3:0] saved_level, new_level;
  logic [SLOT_W-1:0] slot;
  logic [1:0] lat_cnt;
  logic [VEC_W-1:0] mem_rdata;
  logic [3:0] cpu_level;
  logic [N_SRC-1:0] elig, above_lvl;
  logic win_ok, win_trap;
  logic [4:0] win_idx;
  logic [3:0] win_level;
  logic [SLOT_W-1:0] win_slot;
  logic [6:0] win_num;
  logic [VEC_W-1:0] win_loc;
  logic [15:0] rd_mux;
  logic [2:0] ev_set;

  // Register hit decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  wire wr_ctrl1 = wr_i && hit(addr_i, OFF_CTRL1);
  wire wr_ctrl2 = wr_i && hit(addr_i, OFF_CTRL2);
  wire wr_status = wr_i && hit(addr_i, OFF_STATUS);
  wire wr_core = wr_i && hit(addr_i, OFF_CORE);
  wire wr_en_lo = wr_i && hit(addr_i, OFF_EN_LO);
  wire wr_en_hi = wr_i && hit(addr_i, OFF_EN_HI);
  wire wr_stat = wr_i && hit(addr_i, OFF_EV_STAT);
  wire wr_mask = wr_i && hit(addr_i, OFF_EV_MASK);
  wire wr_vidx = wr_i && hit(addr_i, OFF_VEC_IDX);
  wire wr_vlo = wr_i && hit(addr_i, OFF_VEC_LO);
  wire wr_vhi = wr_i && hit(addr_i, OFF_VEC_HI);
  wire [7:0] prio_off = addr_i - OFF_PRIO0;
  wire prio_hit = addr_i >= OFF_PRIO0 && prio_off < 8'((N_SRC + 3) / 4);

  // ---------------------------------------------------------------
  // Winner selection
  // ---------------------------------------------------------------
  // Level is status bits extended by bit three
  assign cpu_level = {cpu_level_bit3, cpu_level_bits};

  // Strictly above the CPU level; level 8..15 or 7 blocks all
  for (genvar g = 0; g < N_SRC; g++) begin : g_above
    assign above_lvl[g] = {1'b0, prio[g]} > cpu_level;
  end
  assign elig = src_req_i & src_en & above_lvl;

  // Traps first, then highest level, ties to lowest position
  always_comb begin
    win_ok = 1'b0;
    win_trap = 1'b0;
    win_idx = '0;
    win_level = '0;
    for (int i = N_TRAP - 1; i >= 0; i--) begin
      if (trap_req_i[i]) begin
        win_ok = 1'b1;
        win_trap = 1'b1;
        win_idx = 5'(i);
        win_level = {1'b1, 3'(MAX_TRAP - 1 - i)};
      end
    end
    if (!win_trap) begin
      for (int i = N_SRC - 1; i >= 0; i--) begin
        if (elig[i] && {1'b0, prio[i]} >= win_level) begin
          win_ok = 1'b1;
          win_idx = 5'(i);
          win_level = {1'b0, prio[i]};
        end
      end
    end
  end

  // Slot in the store, vector number, program location
  assign win_slot = win_trap ? win_idx : SLOT_W'(N_TRAP) + win_idx;
  assign win_num = win_trap ? 7'(win_idx) : 7'(MAX_TRAP) + 7'(win_idx);
  assign win_loc = (alt_table_select ? ALT_TBL_BASE : TBL_BASE)
                   + 24'(win_num) * 24'(VEC_STEP);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Fixed path: idle, fetch, load, request; return lasts RET_LAT
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (win_ok) next_state = ST_FETCH;
      ST_FETCH: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_REQ;
      ST_REQ: if (cpu_ack_i) next_state = ST_SERVE;
      ST_SERVE: if (cpu_ret_i) next_state = ST_RET;
      ST_RET: if (lat_cnt == 2'(RET_LAT - 1)) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      lat_cnt <= '0;
    end else begin
      state <= next_state;
      lat_cnt <= (state == ST_RET) ? lat_cnt + 2'd1 : 2'd0;
    end
  end

  // Capture of the winner at the start of entry
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slot <= '0;
      new_level <= '0;
      cpu_vec_num_o <= '0;
      cpu_vec_loc_o <= '0;
    end else if (state == ST_IDLE && win_ok) begin
      slot <= win_slot;
      new_level <= win_level;
      cpu_vec_num_o <= win_num;
      cpu_vec_loc_o <= win_loc;
    end
  end

  // Request and handler address towards the core
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cpu_req_o <= 1'b0;
      handler_pc_o <= RESET_PC;
    end else begin
      cpu_req_o <= next_state == ST_REQ;
      if (state == ST_LOAD) begin
        handler_pc_o <= mem_rdata;
      end
    end
  end

  // Vector store; alternate half selected by the top address bit
  ivc_vec_mem #(
    .WIDTH(VEC_W),
    .AW(SLOT_W + 1)
  ) u_vec_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(wr_vhi),
    .waddr_i(vec_idx),
    .wdata_i({wdata_i[7:0], vec_lo}),
    .raddr_i({alt_table_select, slot}),
    .rdata_o(mem_rdata)
  );

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nesting_disable <= REG_RST[NEST_DIS_BIT];
      alt_table_select <= REG_RST[ALT_SEL_BIT];
      src_en <= '0;
      vec_idx <= '0;
      vec_lo <= REG_RST;
    end else begin
      if (wr_ctrl1) nesting_disable <= wdata_i[NEST_DIS_BIT];
      if (wr_ctrl2) alt_table_select <= wdata_i[ALT_SEL_BIT];
      if (wr_en_lo) src_en[15:0] <= wdata_i;
      if (wr_en_hi) src_en[N_SRC-1:16] <= wdata_i[N_SRC-17:0];
      if (wr_vidx) vec_idx <= wdata_i[5:0];
      if (wr_vlo) vec_lo <= wdata_i;
    end
  end

  // Priority fields, four per word
  for (genvar g = 0; g < N_SRC; g++) begin : g_prio
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        prio[g] <= '0;
      end else if (wr_i && prio_hit && prio_off == 8'(g / 4)) begin
        prio[g] <= wdata_i[(g % 4) * 4 +: PRIO_W];
      end
    end
  end

  // CPU level: hardware entry and return win over software
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cpu_level_bits <= '0;
      cpu_level_bit3 <= 1'b0;
      saved_level <= '0;
    end else if (state == ST_LOAD) begin
      saved_level <= cpu_level;
      {cpu_level_bit3, cpu_level_bits} <= new_level;
    end else if (state == ST_RET && next_state == ST_IDLE) begin
      {cpu_level_bit3, cpu_level_bits} <= saved_level;
    end else begin
      if (wr_status && !nesting_disable) begin
        cpu_level_bits <= wdata_i[LEVEL_LSB +: 3];
      end
      if (wr_core && !wdata_i[LEVEL3_BIT]) begin
        cpu_level_bit3 <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status, mask and interrupt output
  // ---------------------------------------------------------------
  assign ev_set[EV_ENTRY] = state == ST_LOAD;
  assign ev_set[EV_TRAP] = state == ST_IDLE && win_ok && win_trap;
  assign ev_set[EV_RETURN] = state == ST_RET && next_state == ST_IDLE;

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ev_stat <= '0;
      ev_mask <= '0;
      irq_o <= 1'b0;
    end else begin
      ev_stat <= (ev_stat & ~(wr_stat ? wdata_i[2:0] : 3'b000)) | ev_set;
      if (wr_mask) ev_mask <= wdata_i[2:0];
      irq_o <= |(((ev_stat & ~(wr_stat ? wdata_i[2:0] : 3'b000)) | ev_set)
                 & (wr_mask ? wdata_i[2:0] : ev_mask));
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    if (prio_hit) begin
      for (int j = 0; j < 4; j++) begin
        if (32'(prio_off) * 4 + j < N_SRC) begin
          rd_mux[j * 4 +: PRIO_W] = prio[32'(prio_off) * 4 + j];
        end
      end
    end else begin
      unique case (addr_i)
        OFF_CTRL1: rd_mux[NEST_DIS_BIT] = nesting_disable;
        OFF_CTRL2: rd_mux[ALT_SEL_BIT] = alt_table_select;
        OFF_STATUS: rd_mux[LEVEL_LSB +: 3] = cpu_level_bits;
        OFF_CORE: rd_mux[LEVEL3_BIT] = cpu_level_bit3;
        OFF_EN_LO: rd_mux = src_en[15:0];
        OFF_EN_HI: rd_mux[N_SRC-17:0] = src_en[N_SRC-1:16];
        OFF_EV_STAT: rd_mux[2:0] = ev_stat;
        OFF_EV_MASK: rd_mux[2:0] = ev_mask;
        OFF_VEC_IDX: rd_mux[5:0] = vec_idx;
        OFF_VEC_LO: rd_mux = vec_lo;
        OFF_ACTIVE: rd_mux = {3'b000, state, cpu_vec_num_o};
        default: rd_mux = '0;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      cpu_level_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 16'h0000;
      cpu_level_o <= cpu_level;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence seq_capture;
    state == ST_IDLE && win_ok;
  endsequence

  sequence seq_ret_start;
    state == ST_SERVE && cpu_ret_i;
  endsequence

  chk_req_single: assert property (cpu_req_o |-> state == ST_REQ)
    else $error("request outside request state");
  chk_entry_lat: assert property (seq_capture |-> ##3 cpu_req_o)
    else $error("entry latency wrong");
  chk_return_lat: assert property (
    seq_ret_start |=> state == ST_RET [*2] ##1 state == ST_IDLE)
    else $error("return latency wrong");
  chk_trap_first: assert property (
    state == ST_IDLE && |trap_req_i |-> win_ok && win_trap)
    else $error("trap not forwarded");
  chk_level_gate: assert property (
    cpu_level_bit3 || cpu_level_bits == 3'h7 |-> elig == '0)
    else $error("user source passed a blocking level");
  chk_vec_loc: assert property (
    seq_capture |=> cpu_vec_loc_o == ($past(alt_table_select) ? ALT_TBL_BASE : TBL_BASE)
      + 24'($past(win_num)) * 24'(VEC_STEP))
    else $error("vector location wrong");
  chk_handler_load: assert property (
    state == ST_LOAD |=> handler_pc_o == $past(mem_rdata))
    else $error("handler address not loaded");
  chk_level_lock: assert property (
    nesting_disable && wr_status && state == ST_IDLE |=> cpu_level_bits == $past(cpu_level_bits))
    else $error("level bits written while locked");
  chk_reset_pc: assert property (@(posedge mclk_i)
    $past(rst_i) |-> handler_pc_o == RESET_PC)
    else $error("program counter not zero after reset");

endmodule : ivc_ctrl

`default_nettype wire

// ==== ivc_cpu_model.sv ====
/*
  Behavioural CPU core facing the interrupt controller: accepts the request
  after a set delay, serves a few cycles, then signals return.
  Assumes the controller and this model share one clock and reset.
*/
`default_nettype none

module ivc_cpu_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cpu_req_i,
  input wire logic [3:0] ack_dly_i,
  output logic cpu_ack_o,
  output logic cpu_ret_o,
  output logic [7:0] ret_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Accept, serve, return
  // ---------------------------------------------------------------
  localparam logic [3:0] SVC_CYC = 4'h4;
  logic [3:0] cnt;
  logic in_svc;

  // Ack one cycle after delay; return only once request has dropped
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      in_svc <= 1'b0;
      cpu_ack_o <= 1'b0;
      cpu_ret_o <= 1'b0;
      ret_cnt_o <= 8'h00;
    end else begin
      cpu_ack_o <= 1'b0;
      cpu_ret_o <= 1'b0;
      if (cpu_req_i && !in_svc) begin
        cnt <= (cnt >= ack_dly_i) ? 4'h0 : cnt + 4'h1;
        cpu_ack_o <= (cnt >= ack_dly_i);
        in_svc <= (cnt >= ack_dly_i);
      end else if (in_svc && !cpu_req_i && !cpu_ack_o) begin
        cnt <= (cnt == SVC_CYC) ? 4'h0 : cnt + 4'h1;
        cpu_ret_o <= (cnt == SVC_CYC);
        in_svc <= (cnt != SVC_CYC);
        ret_cnt_o <= ret_cnt_o + 8'((cnt == SVC_CYC));
      end
    end
  end
endmodule : ivc_cpu_model

`default_nettype wire

// ==== tb_vectored_interrupt_controller.sv ====
/*
  Self-checking bench of the interrupt controller: table of sources, then
  ties, traps, event interrupt, level blocking and a mid-run reset.
  Assumes the CPU model in ivc_cpu_model.sv answers the request port.
*/
`default_nettype none

module tb_vectored_interrupt_controller;
  import ivc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  typedef struct {logic [4:0] src; logic [2:0] prio; logic alt; logic [23:0] pc;} ivc_row_s;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [27:0] src_req_i = '0;
  logic [3:0] trap_req_i = 4'h0;
  logic [3:0] ack_dly = 4'h0;
  logic [15:0] rdata_o;
  logic cpu_ack, cpu_ret, cpu_req_o, irq_o;
  logic [6:0] cpu_vec_num_o;
  logic [23:0] cpu_vec_loc_o, handler_pc_o;
  logic [3:0] cpu_level_o;
  logic [7:0] ret_cnt;
  int bad_count = 0;
  int checked = 0;
  ivc_row_s rows [4] = '{'{5'd0, 3'd1, 1'b0, 24'h01_2340}, '{5'd27, 3'd7, 1'b1, 24'hAB_CDEF},
    '{5'd13, 3'd4, 1'b0, 24'h00_3000}, '{5'd16, 3'd3, 1'b1, 24'h7F_0F0F}};

  ivc_ctrl u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_req_i(src_req_i),
    .trap_req_i(trap_req_i), .cpu_ack_i(cpu_ack), .cpu_ret_i(cpu_ret), .cpu_req_o(cpu_req_o),
    .cpu_vec_num_o(cpu_vec_num_o), .cpu_vec_loc_o(cpu_vec_loc_o),
    .handler_pc_o(handler_pc_o), .cpu_level_o(cpu_level_o), .irq_o(irq_o));
  ivc_cpu_model u_cpu (.mclk_i(mclk_i), .rst_i(rst_i), .cpu_req_i(cpu_req_o),
    .ack_dly_i(ack_dly), .cpu_ack_o(cpu_ack), .cpu_ret_o(cpu_ret), .ret_cnt_o(ret_cnt));

  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bail(input int n);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
  endtask : bail

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 check(24'(rdata_o), 24'(e));
  endtask : rd

  task automatic set_vec(input logic alt, input logic [4:0] slot, input logic [23:0] v);
    wr(OFF_VEC_IDX, {10'h000, alt, slot});
    wr(OFF_VEC_LO, v[15:0]);
    wr(OFF_VEC_HI, {8'h00, v[23:16]});
  endtask : set_vec

  // Raise requests, follow one service to its return
  task automatic run_irq(input logic [27:0] s, input logic [3:0] t, input logic [6:0] num,
      input logic [23:0] loc, input logic [23:0] pc, input logic [3:0] lvl,
      input logic [3:0] rl);
    int n;
    logic [7:0] r0;
    @(posedge mclk_i);
    src_req_i <= s;
    trap_req_i <= t;
    r0 = ret_cnt;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (cpu_req_o !== 1'b1 && n < 50);
    bail(n);
    // Request stands three edges after the source rises
    check(24'(n), 24'h00_0003);
    check(24'(cpu_vec_num_o), 24'(num));
    check(cpu_vec_loc_o, loc);
    check(handler_pc_o, pc);
    for (n = 0; cpu_req_o !== 1'b0 && n < 50; n++) @(posedge mclk_i);
    bail(n);
    src_req_i <= '0;
    trap_req_i <= 4'h0;
    @(posedge mclk_i);
    #1 check(24'(cpu_level_o), 24'(lvl));
    for (n = 0; ret_cnt == r0 && n < 50; n++) @(posedge mclk_i);
    bail(n);
    repeat (4) @(posedge mclk_i);
    #1 check(24'(cpu_level_o), 24'(rl));
  endtask : run_irq

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [23:0] loc;
    int n;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Table rows: one source each, both tables, prompt and slow ack
    foreach (rows[i]) begin
      ack_dly <= 4'(i);
      wr(OFF_CTRL2, {rows[i].alt, 15'h0000});
      set_vec(rows[i].alt, 5'(4 + rows[i].src), rows[i].pc);
      wr(OFF_PRIO0 + 8'(rows[i].src / 4), 16'(rows[i].prio) << (4 * (rows[i].src % 4)));
      wr(OFF_EN_LO, (rows[i].src < 16) ? 16'(1) << rows[i].src : 16'h0000);
      wr(OFF_EN_HI, (rows[i].src >= 16) ? 16'(1) << (rows[i].src - 16) : 16'h0000);
      loc = (rows[i].alt ? ALT_TBL_BASE : TBL_BASE) + 24'(2 * (8 + rows[i].src));
      run_irq(28'(1) << rows[i].src, 4'h0, 7'(8 + rows[i].src), loc, rows[i].pc,
        {1'b0, rows[i].prio}, 4'h0);
      rd(OFF_EV_STAT, 16'h0005);
      wr(OFF_EV_STAT, 16'h0007);
      rd(OFF_EV_STAT, 16'h0000);
    end
    wr(OFF_CTRL2, 16'h0000);
    // Equal priority tie: lower index wins
    set_vec(1'b0, 5'd7, 24'h00_0703);
    set_vec(1'b0, 5'd13, 24'h00_0D09);
    set_vec(1'b1, 5'd7, 24'h00_0703);
    wr(OFF_PRIO0, 16'h5000);
    wr(OFF_PRIO0 + 8'h02, 16'h0050);
    wr(OFF_EN_LO, 16'h0208);
    run_irq(28'h000_0208, 4'h0, 7'd11, TBL_BASE + 24'd22, 24'h00_0703, 4'h5, 4'h0);
    // Traps beat user sources, first trap wins
    set_vec(1'b0, 5'd1, 24'h00_7770);
    run_irq(28'h000_0008, 4'h6, 7'd1, TBL_BASE + 24'd2, 24'h00_7770, 4'he, 4'h0);
    // Event status, mask and interrupt line
    rd(OFF_EV_STAT, 16'h0007);
    check(24'(irq_o), 24'h0);
    wr(OFF_EV_MASK, 16'h0002);
    repeat (2) @(posedge mclk_i);
    #1 check(24'(irq_o), 24'h1);
    wr(OFF_EV_STAT, 16'h0002);
    repeat (2) @(posedge mclk_i);
    #1 check(24'(irq_o), 24'h0);
    rd(OFF_EV_STAT, 16'h0005);
    // Level at source priority blocks, one above passes
    wr(OFF_STATUS, 16'h00A0);
    rd(OFF_STATUS, 16'h00A0);
    wr(OFF_EN_LO, 16'h0008);
    src_req_i <= 28'h000_0008;
    n = 0;
    repeat (20) begin
      @(posedge mclk_i);
      #1 n += int'(cpu_req_o !== 1'b0);
    end
    check(24'(n), 24'h0);
    src_req_i <= '0;
    wr(OFF_PRIO0, 16'h6000);
    run_irq(28'h000_0008, 4'h0, 7'd11, TBL_BASE + 24'd22, 24'h00_0703, 4'h6, 4'h5);
    // Level bits frozen while nesting is disabled
    wr(OFF_CTRL1, 16'h8000);
    wr(OFF_STATUS, 16'h0000);
    rd(OFF_STATUS, 16'h00A0);
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_STATUS, 16'h0000);
    rd(OFF_STATUS, 16'h0000);
    wr(OFF_CORE, 16'h0008);
    rd(OFF_CORE, 16'h0000);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    // Second reset in mid-run clears all but the vector store; handler, irq, request and level outputs, offsets 0 to 7 and the active word are checked
    wr(OFF_CTRL2, 16'h8000);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 check(handler_pc_o, RESET_PC);
    check(24'({irq_o, cpu_req_o, cpu_level_o}), 24'h0);
    for (int a = 0; a < 8; a++) rd(8'(a), REG_RST);
    rd(OFF_ACTIVE, {3'b000, ST_IDLE, 7'h00});
    give_verdict();
  end
endmodule : tb_vectored_interrupt_controller

`default_nettype wire
